// file: rtl/hlink_pkg.sv
package hlink_pkg;

  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_RATE_CTRL   = 12'h04c;
  localparam logic [11:0] IDX_RATE_CAP    = 12'h04e;
  localparam logic [11:0] IDX_WIN0_LO     = 12'h140;
  localparam logic [11:0] IDX_WIN0_HI     = 12'h141;
  localparam logic [11:0] IDX_EVT_STATUS  = 12'h180;
  localparam logic [11:0] IDX_EVT_MASK    = 12'h181;
  localparam logic [11:0] IDX_RATE_ACTIVE = 12'h182;

  // ---------------------------------------------------------------
  // Reset values and field positions.
  // ---------------------------------------------------------------
  localparam logic [15:0] RATE_CTRL_RESET = 16'h0060;
  localparam logic [15:0] RATE_CAP_RESET  = 16'h0000;
  localparam logic [63:0] WIN0_RESET      = 64'h0000f0008000000;
  localparam int          OVF_BIT         = 13;
  localparam int          PROTO_BIT       = 12;
  localparam int          RATE_LSB        = 8;
  localparam int          RATE_W          = 4;
  localparam int          BASE_LSB        = 48;
  localparam int          MASK_LSB        = 32;
  localparam int          WEN_BIT         = 31;
  localparam int          TEN_BIT         = 30;
  localparam int          TRANS_W         = 30;
  localparam int          HI_W            = 16;
  localparam int          IN_ADDR_W       = 40;
  localparam int          OUT_ADDR_W      = 54;
  localparam int          PAGE_LSB        = 24;

  // Event bits of the sticky status and mask registers.
  localparam int          EV_OVF          = 0;
  localparam int          EV_PROTO        = 1;
  localparam int          EV_MISS         = 2;
  localparam int          EV_W            = 3;

  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // Link rate of each capability bit, in MHz.
  localparam logic [11:0] RATE_MHZ [0:15] = '{
    12'd200, 12'd300, 12'd400, 12'd500, 12'd600, 12'd800, 12'd1000, 12'd1200,
    12'd1400, 12'd1600, 12'd1800, 12'd2000, 12'd2200, 12'd2400, 12'd2600, 12'd3200};

  // Pins crossing into CLK: link clock, valid, address, bad command,
  // overflow, disconnect, warm reset, capability strap.
  localparam int          SYNC_W          = 1 + 1 + IN_ADDR_W + 4 + 16;
  localparam logic [1:0]  STRAP_WAIT      = 2'd3;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_CTRL, SEL_CAP, SEL_WLO, SEL_WHI, SEL_STAT, SEL_MASK, SEL_ACT
  } reg_sel_t;

endpackage

// file: rtl/inbound_window.sv
`timescale 1ns/1ps
`default_nettype none
module inbound_window
  import hlink_pkg::*;
(
  // Window configuration word
  input  wire logic [63:0]             cfg,
  // Incoming request address
  input  wire logic [IN_ADDR_W-1:0]    addr_in,
  // Decode result
  output logic                         hit,
  output logic [OUT_ADDR_W-1:0]        addr_out
);

  logic [HI_W-1:0]    base;
  logic [HI_W-1:0]    mask;
  logic [HI_W-1:0]    page;
  logic [TRANS_W-1:0] trans;

  assign base  = cfg[BASE_LSB +: HI_W];
  assign mask  = cfg[MASK_LSB +: HI_W];
  assign trans = cfg[TRANS_W-1:0];
  assign page  = addr_in[PAGE_LSB +: HI_W];

  // The window compares only the high sixteen bits of the address.
  assign hit = cfg[WEN_BIT] && ((page & mask) == (base & mask)); // [RULE_10]

  always_comb begin
    if (cfg[TEN_BIT]) begin
      addr_out = {trans[TRANS_W-1:HI_W], // [RULE_12]
                  (page & ~mask) | (trans[HI_W-1:0] & mask), // [RULE_11] [RULE_13]
                  addr_in[PAGE_LSB-1:0]};
    end else begin
      addr_out = {{(OUT_ADDR_W-IN_ADDR_W){1'b0}}, addr_in}; // [RULE_14]
    end
  end

endmodule
`default_nettype wire

// file: rtl/host_link_rate_window.sv
// Contract
// RULE_01: Read-only bit reports link packet overflow.
// RULE_02: Unrecognized link command sets protocol error bit.
// RULE_03: Rate field indexes a capability bit.
// RULE_04: Software programs only supported rate indices.
// RULE_05: New rate applies at warm reset/disconnect.
// RULE_06: Sixteen-bit read-only capability mask.
// RULE_07: Capability bits map to fixed link rates.
// RULE_08: Capability comes from external clock strap.
// RULE_09: Forward only accesses hitting enabled window.
// RULE_10: Hit when masked address equals masked base.
// RULE_11: Translation keeps unmasked incoming address bits.
// RULE_12: Thirty-bit field supplies output bits 53:24.
// RULE_13: Masked bits replaced by translation field bits.
// RULE_14: Untranslated hit forwards address unchanged.
`timescale 1ns/1ps
`default_nettype none
module host_link_rate_window
  import hlink_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h60
)(
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  // AXI4-Lite write address and data
  input  wire logic [31:0]           AWADDR,
  input  wire logic                  AWVALID,
  output logic                       AWREADY,
  input  wire logic [31:0]           WDATA,
  input  wire logic [3:0]            WSTRB,
  input  wire logic                  WVALID,
  output logic                       WREADY,
  // AXI4-Lite write response
  output logic [1:0]                 BRESP,
  output logic                       BVALID,
  input  wire logic                  BREADY,
  // AXI4-Lite read
  input  wire logic [31:0]           ARADDR,
  input  wire logic                  ARVALID,
  output logic                       ARREADY,
  output logic [31:0]                RDATA,
  output logic [1:0]                 RRESP,
  output logic                       RVALID,
  input  wire logic                  RREADY,
  // Host link pins, all asynchronous to CLK
  input  wire logic                  LINK_CLK,
  input  wire logic                  LINK_VALID,
  input  wire logic [IN_ADDR_W-1:0]  LINK_ADDR,
  input  wire logic                  LINK_BAD_CMD,
  input  wire logic                  LINK_OVERFLOW,
  input  wire logic                  LINK_DISCONNECT,
  input  wire logic                  WARM_RESET,
  input  wire logic [15:0]           CAP_STRAP,
  // Forwarded request to internal devices
  output logic                       FWD_VALID,
  output logic [OUT_ADDR_W-1:0]      FWD_ADDR,
  // Active link rate
  output logic [RATE_W-1:0]          LINK_RATE,
  output logic [11:0]                LINK_RATE_MHZ,
  // Interrupt
  output logic                       IRQ
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0]    sync1;
  logic [SYNC_W-1:0]    sync2;
  logic                 lclk_d;
  logic                 disc_d;
  logic                 warm_d;
  logic                 lclk_s;
  logic                 valid_s;
  logic [IN_ADDR_W-1:0] addr_s;
  logic                 bad_s;
  logic                 ovf_s;
  logic                 disc_s;
  logic                 warm_s;
  logic [15:0]          strap_s;
  logic                 link_rise;
  logic                 apply_evt;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync1  <= '0;
      sync2  <= '0;
      lclk_d <= 1'b0;
      disc_d <= 1'b0;
      warm_d <= 1'b0;
    end else begin
      sync1  <= {LINK_CLK, LINK_VALID, LINK_ADDR, LINK_BAD_CMD, LINK_OVERFLOW,
                 LINK_DISCONNECT, WARM_RESET, CAP_STRAP};
      sync2  <= sync1;
      lclk_d <= lclk_s;
      disc_d <= disc_s;
      warm_d <= warm_s;
    end
  end

  assign {lclk_s, valid_s, addr_s, bad_s, ovf_s, disc_s, warm_s, strap_s} = sync2;
  assign link_rise = lclk_s & ~lclk_d;
  // Both events are edges, so a held disconnect applies the rate only once.
  assign apply_evt = (disc_s & ~disc_d) | (warm_s & ~warm_d);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [RATE_W-1:0] pending;
  logic [RATE_W-1:0] applied;
  logic [15:0]       cap;
  logic [1:0]        strap_cnt;
  logic [63:0]       win0;
  logic [EV_W-1:0]   status;
  logic [EV_W-1:0]   mask;
  logic [EV_W-1:0]   ev_set;
  logic [EV_W-1:0]   ev_clr;
  logic              win_hit;
  logic [OUT_ADDR_W-1:0] win_addr;

  inbound_window u_window (
    .cfg      (win0),
    .addr_in  (addr_s),
    .hit      (win_hit),
    .addr_out (win_addr)
  );

  function automatic reg_sel_t decode(input logic [31:0] a);
    logic [11:0] idx;
    idx = a[13:2];
    if (a[31:14] != '0 || a[1:0] != 2'b00) return SEL_NONE;
    unique case (idx)
      IDX_RATE_CTRL:   return SEL_CTRL;
      IDX_RATE_CAP:    return SEL_CAP;
      IDX_WIN0_LO:     return SEL_WLO;
      IDX_WIN0_HI:     return SEL_WHI;
      IDX_EVT_STATUS:  return SEL_STAT;
      IDX_EVT_MASK:    return SEL_MASK;
      IDX_RATE_ACTIVE: return SEL_ACT;
      default:         return SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        do_write;
  reg_sel_t    wsel;
  logic        next_aw_held;
  logic        next_w_held;
  logic        next_bvalid;

  assign do_write     = aw_held & w_held & ~BVALID;
  assign wsel         = decode(wr_addr);
  assign next_aw_held = (aw_held | (AWVALID & AWREADY)) & ~do_write;
  assign next_w_held  = (w_held | (WVALID & WREADY)) & ~do_write;
  assign next_bvalid  = do_write | (BVALID & ~BREADY);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) wr_addr <= AWADDR;
      if (WVALID && WREADY) begin
        wr_data <= WDATA;
        wr_strb <= WSTRB;
      end
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      AWREADY <= ~next_aw_held & ~next_bvalid;
      WREADY  <= ~next_w_held & ~next_bvalid;
      BVALID  <= next_bvalid;
      if (do_write) BRESP <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pending <= RATE_CTRL_RESET[RATE_LSB +: RATE_W];
      win0    <= WIN0_RESET;
      mask    <= '0;
    end else if (do_write) begin
      unique case (wsel)
        // Only the rate field is writable; it waits here until applied.
        SEL_CTRL: if (wr_strb[1]) pending <= wr_data[RATE_LSB +: RATE_W]; // [RULE_05]
        SEL_WLO:  win0[31:0]  <= merge(win0[31:0], wr_data, wr_strb);
        SEL_WHI:  win0[63:32] <= merge(win0[63:32], wr_data, wr_strb);
        SEL_MASK: if (wr_strb[0]) mask <= wr_data[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Link rate and capability
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      applied       <= RATE_CTRL_RESET[RATE_LSB +: RATE_W];
      LINK_RATE     <= RATE_CTRL_RESET[RATE_LSB +: RATE_W];
      LINK_RATE_MHZ <= RATE_MHZ[RATE_CTRL_RESET[RATE_LSB +: RATE_W]];
    end else begin
      if (apply_evt) applied <= pending; // [RULE_05]
      LINK_RATE     <= applied; // [RULE_03]
      LINK_RATE_MHZ <= RATE_MHZ[applied]; // [RULE_07]
    end
  end

  // The strap is caught once after reset, when the synchroniser holds it.
  // Under software PLL control the strap, and so this mask, means nothing.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      strap_cnt <= '0;
      cap       <= RATE_CAP_RESET;
    end else if (strap_cnt != STRAP_WAIT) begin
      strap_cnt <= strap_cnt + 2'd1;
      if (strap_cnt == STRAP_WAIT - 2'd1) cap <= strap_s; // [RULE_08] [RULE_06]
    end
  end

  // ---------------------------------------------------------------
  // Inbound decode and link events
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      FWD_VALID <= 1'b0;
      FWD_ADDR  <= '0;
    end else begin
      FWD_VALID <= link_rise & valid_s & win_hit; // [RULE_09]
      if (link_rise && valid_s && win_hit) FWD_ADDR <= win_addr;
    end
  end

  assign ev_set[EV_OVF]   = link_rise & ovf_s; // [RULE_01]
  assign ev_set[EV_PROTO] = link_rise & bad_s; // [RULE_02]
  assign ev_set[EV_MISS]  = link_rise & valid_s & ~win_hit;
  assign ev_clr = (do_write && wsel == SEL_STAT && wr_strb[0]) ? wr_data[EV_W-1:0] : '0;

  // A set in the cycle of a clear wins, so no event is lost.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      status <= '0;
      IRQ    <= 1'b0;
    end else begin
      status <= (status & ~ev_clr) | ev_set;
      IRQ    <= |(status & mask);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  reg_sel_t    rsel;
  logic [31:0] rd_word;

  assign rsel = decode(ARADDR);

  always_comb begin
    rd_word = '0;
    unique case (rsel)
      SEL_CTRL: rd_word = {16'h0000, 2'b00, status[EV_OVF], status[EV_PROTO], // [RULE_01] [RULE_02]
                           pending, REVISION};
      SEL_CAP:  rd_word = {16'h0000, cap}; // [RULE_06]
      SEL_WLO:  rd_word = win0[31:0];
      SEL_WHI:  rd_word = win0[63:32];
      SEL_STAT: rd_word = {29'h0, status};
      SEL_MASK: rd_word = {29'h0, mask};
      SEL_ACT:  rd_word = {28'h0, applied};
      default:  rd_word = '0;
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_word;
      RRESP   <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end else if (!RVALID) begin
      ARREADY <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_overflow;
    @(posedge CLK) disable iff (RESET) link_rise && ovf_s |=> status[EV_OVF];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // [RULE_01]

  property p_proto;
    @(posedge CLK) disable iff (RESET) link_rise && bad_s |=> status[EV_PROTO] [*2];
  endproperty
  a_proto: assert property (p_proto) else $error("protocol error not held"); // [RULE_02]

  property p_rate_hold;
    @(posedge CLK) disable iff (RESET) !apply_evt |=> applied == $past(applied);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate changed early"); // [RULE_05]

  property p_rate_apply;
    @(posedge CLK) disable iff (RESET) apply_evt |=> ##1 LINK_RATE == $past(pending, 2);
  endproperty
  a_rate_apply: assert property (p_rate_apply) else $error("rate not applied"); // [RULE_03]

  property p_mhz;
    @(posedge CLK) disable iff (RESET) LINK_RATE == 4'd4 && $stable(LINK_RATE)
      |-> LINK_RATE_MHZ == 12'd600;
  endproperty
  a_mhz: assert property (p_mhz) else $error("index 4 is not 600 MHz"); // [RULE_07]

  property p_cap_fixed;
    @(posedge CLK) disable iff (RESET) strap_cnt == STRAP_WAIT |=> $stable(cap);
  endproperty
  a_cap_fixed: assert property (p_cap_fixed) else $error("capability moved"); // [RULE_08]

  property p_fwd_cause;
    @(posedge CLK) disable iff (RESET)
      FWD_VALID |-> $past(link_rise && valid_s && win0[WEN_BIT]);
  endproperty
  a_fwd_cause: assert property (p_fwd_cause) else $error("forward without hit"); // [RULE_09]

  property p_hit;
    @(posedge CLK) disable iff (RESET) link_rise && valid_s && win0[WEN_BIT] &&
      ((addr_s[39:24] & win0[47:32]) == (win0[63:48] & win0[47:32])) |=> FWD_VALID;
  endproperty
  a_hit: assert property (p_hit) else $error("hit not forwarded"); // [RULE_10]

  property p_keep;
    @(posedge CLK) disable iff (RESET) link_rise && valid_s && win_hit && win0[TEN_BIT]
      |=> ((FWD_ADDR[39:24] ^ $past(addr_s[39:24])) & ~$past(win0[47:32])) == 16'h0000
          && FWD_ADDR[53:40] == $past(win0[29:16]);
  endproperty
  a_keep: assert property (p_keep) else $error("translation wrong"); // [RULE_11]

  property p_pass;
    @(posedge CLK) disable iff (RESET) link_rise && valid_s && win_hit && !win0[TEN_BIT]
      |=> FWD_ADDR == {14'h0000, $past(addr_s)};
  endproperty
  a_pass: assert property (p_pass) else $error("address altered"); // [RULE_14]

  property p_irq;
    @(posedge CLK) disable iff (RESET) |(status & mask) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  c_fwd:   cover property (@(posedge CLK) disable iff (RESET) FWD_VALID);
  c_miss:  cover property (@(posedge CLK) disable iff (RESET) ev_set[EV_MISS]);
  c_apply: cover property (@(posedge CLK) disable iff (RESET) apply_evt && pending != applied);
  c_clear: cover property (@(posedge CLK) disable iff (RESET) |(ev_clr & status));

endmodule
`default_nettype wire

// file: bench/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model
  import hlink_pkg::*;
(
  // Bench clock
  input  wire logic                 CLK,
  // Host link pins
  output var logic                  LINK_CLK,
  output var logic                  LINK_VALID,
  output var logic [IN_ADDR_W-1:0]  LINK_ADDR,
  output var logic                  LINK_BAD_CMD,
  output var logic                  LINK_OVERFLOW
);
  initial begin
    LINK_CLK = 1'b0;
    LINK_VALID = 1'b0;
    LINK_ADDR = '0;
    LINK_BAD_CMD = 1'b0;
    LINK_OVERFLOW = 1'b0;
  end

  // The link clock runs only inside a frame, high for 80 ns. Once a
  // frame is over the address shows the inverse of its last value, so a
  // design that samples it late sees wrong data instead of a stale copy.
  task automatic send(input logic v, input logic [IN_ADDR_W-1:0] a,
                      input logic bad, input logic ovf);
    LINK_VALID <= v;
    LINK_ADDR <= a;
    LINK_BAD_CMD <= bad;
    LINK_OVERFLOW <= ovf;
    repeat (8) @(posedge CLK);
    LINK_CLK <= 1'b1;
    repeat (16) @(posedge CLK);
    LINK_CLK <= 1'b0;
    repeat (8) @(posedge CLK);
    LINK_VALID <= 1'b0;
    LINK_ADDR <= ~a;
    LINK_BAD_CMD <= 1'b0;
    LINK_OVERFLOW <= 1'b0;
    repeat (8) @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// file: bench/tb_host_link_rate_window.sv
`timescale 1ns/1ps
`default_nettype none
module tb_host_link_rate_window
  import hlink_pkg::*;
;
  localparam int LIM = 200;
  typedef struct packed {
    logic [31:0]           hi;
    logic [31:0]           lo;
    logic [IN_ADDR_W-1:0]  a;
    logic                  hit;
    logic [OUT_ADDR_W-1:0] o;
  } row_t;

  logic                  CLK, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic                  ARVALID, ARREADY, RVALID, RREADY, LINK_CLK, LINK_VALID;
  logic                  LINK_BAD_CMD, LINK_OVERFLOW, LINK_DISCONNECT, WARM_RESET;
  logic                  FWD_VALID, IRQ;
  logic [31:0]           AWADDR, WDATA, ARADDR, RDATA, rdat;
  logic [3:0]            WSTRB, LINK_RATE;
  logic [1:0]            BRESP, RRESP, resp;
  logic [IN_ADDR_W-1:0]  LINK_ADDR;
  logic [15:0]           CAP_STRAP;
  logic [OUT_ADDR_W-1:0] FWD_ADDR, fwd_last;
  logic [11:0]           LINK_RATE_MHZ;
  int                    fails, checked, fwd_cnt, n0;

  // ----------------------------------------------------------------
  // Ordinary window decodes: configuration, link address, result.
  // ----------------------------------------------------------------
  row_t rows [0:6] = '{
    '{32'h0000f000, 32'h80000000, 40'h0123456789, 1'b1, 54'h0000123456789},
    '{32'h0000f000, 32'h80000000, 40'h1000000000, 1'b0, 54'h0},
    '{32'h0000f000, 32'h00000000, 40'h0000000001, 1'b0, 54'h0},
    '{32'ha000f000, 32'hd2345000, 40'ha12f00ff11, 1'b1, 54'h1234512f00ff11},
    '{32'h00ffffff, 32'hffffbeef, 40'h00ff000000, 1'b1, 54'h3fffbeef000000},
    '{32'h12340000, 32'hc0010000, 40'hfedcba9876, 1'b1, 54'h1fedcba9876},
    '{32'h80008000, 32'hbfffffff, 40'h8000000abc, 1'b1, 54'h8000000abc}};
  // ----------------------------------------------------------------

  host_link_rate_window dut (.CLK, .RESET, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .LINK_CLK, .LINK_VALID, .LINK_ADDR, .LINK_BAD_CMD,
    .LINK_OVERFLOW, .LINK_DISCONNECT, .WARM_RESET, .CAP_STRAP, .FWD_VALID, .FWD_ADDR,
    .LINK_RATE, .LINK_RATE_MHZ, .IRQ);
  host_link_model host (.CLK, .LINK_CLK, .LINK_VALID, .LINK_ADDR, .LINK_BAD_CMD,
    .LINK_OVERFLOW);

  always #2.5 CLK = ~CLK;
  always @(posedge CLK) if (FWD_VALID === 1'b1) begin
    fwd_cnt <= fwd_cnt + 1;
    fwd_last <= FWD_ADDR;
  end

  function automatic logic [31:0] ba(input logic [11:0] i);
    return {18'h0, i, 2'b00};
  endfunction
  function automatic logic [11:0] mhz(input int i);
    if (i == 15) return 12'd3200;
    if (i >= 6) return 12'(1000 + 200 * (i - 6));
    if (i == 5) return 12'd800;
    return 12'(200 + 100 * i);
  endfunction

  task automatic print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= LIM) begin
      fails++;
      $display("wrong value handshake expected done seen timeout");
      print_verdict();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw, w;
    int   n;
    aw = 1'b1;
    w = 1'b1;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < LIM; n++) begin
      @(posedge CLK);
      if (!aw && !w && BVALID === 1'b1) break;
      if (aw && AWREADY === 1'b1) begin
        AWVALID <= 1'b0;
        aw = 1'b0;
      end
      if (w && WREADY === 1'b1) begin
        WVALID <= 1'b0;
        w = 1'b0;
      end
    end
    resp = BRESP;
    BREADY <= 1'b0;
    // Let an edge pass so that a following call never drives BREADY twice at once.
    @(posedge CLK);
    tmo(n);
  endtask
  task automatic rd(input logic [31:0] a);
    logic ar;
    int   n;
    ar = 1'b1;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < LIM; n++) begin
      @(posedge CLK);
      if (!ar && RVALID === 1'b1) break;
      if (ar && ARREADY === 1'b1) begin
        ARVALID <= 1'b0;
        ar = 1'b0;
      end
    end
    rdat = RDATA;
    resp = RRESP;
    RREADY <= 1'b0;
    // Let an edge pass so that a following call never drives RREADY twice at once.
    @(posedge CLK);
    tmo(n);
  endtask
  task automatic pulse(input logic warm);
    if (warm) WARM_RESET <= 1'b1;
    else LINK_DISCONNECT <= 1'b1;
    repeat (8) @(posedge CLK);
    WARM_RESET <= 1'b0;
    LINK_DISCONNECT <= 1'b0;
    repeat (8) @(posedge CLK);
  endtask

  initial begin
    {CLK, AWVALID, WVALID, BREADY, ARVALID, RREADY, LINK_DISCONNECT, WARM_RESET} = '0;
    {AWADDR, WDATA, ARADDR, fails, checked, fwd_cnt} = '0;
    RESET = 1'b1;
    WSTRB = 4'hf;
    CAP_STRAP = 16'hffff;
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    repeat (8) @(posedge CLK);
    foreach (rows[i]) begin
      wr(ba(IDX_WIN0_HI), rows[i].hi);
      wr(ba(IDX_WIN0_LO), rows[i].lo);
      rd(ba(IDX_WIN0_HI));
      chk("win_hi", 64'(rows[i].hi), 64'(rdat));
      n0 = fwd_cnt;
      host.send(1'b1, rows[i].a, 1'b0, 1'b0);
      chk("fwd_count", 64'(rows[i].hit), 64'(fwd_cnt - n0));
      if (rows[i].hit) chk("fwd_addr", 64'(rows[i].o), 64'(fwd_last));
    end
    // Pending rates must not reach the link until the next apply event.
    for (int i = 0; i < 16; i++) begin
      wr(ba(IDX_RATE_CTRL), 32'(i) << RATE_LSB);
      rd(ba(IDX_RATE_CTRL));
      chk("rate_pending", 64'(i), 64'(rdat[RATE_LSB+:RATE_W]));
      chk("rate_held", 64'((i == 0) ? 0 : i - 1), 64'(LINK_RATE));
      pulse(i[0]);
      chk("rate_active", 64'(i), 64'(LINK_RATE));
      chk("rate_mhz", 64'(mhz(i)), 64'(LINK_RATE_MHZ));
      rd(ba(IDX_RATE_ACTIVE));
      chk("rate_applied", 64'(i), 64'(rdat));
    end
    host.send(1'b0, 40'h0, 1'b1, 1'b0);
    host.send(1'b0, 40'h0, 1'b0, 1'b1);
    rd(ba(IDX_EVT_STATUS));
    chk("status", 64'h7, 64'(rdat));
    chk("irq_masked", 64'h0, 64'(IRQ));
    wr(ba(IDX_EVT_MASK), 32'h2);
    rd(ba(IDX_EVT_MASK));
    chk("mask", 64'h2, 64'(rdat));
    repeat (3) @(posedge CLK);
    chk("irq_on", 64'h1, 64'(IRQ));
    wr(ba(IDX_EVT_STATUS), 32'h2);
    wr(ba(IDX_RATE_CTRL), 32'h3000);
    repeat (3) @(posedge CLK);
    chk("irq_off", 64'h0, 64'(IRQ));
    rd(ba(IDX_RATE_CTRL));
    chk("ctrl_err", 64'h2, 64'(rdat[13:12]));
    rd(32'h7fc);
    chk("unmapped_rd", {62'h0, RESP_SLVERR}, {62'h0, resp});
    chk("unmapped_data", 64'h0, 64'(rdat));
    wr(32'h7fc, 32'hffffffff);
    chk("unmapped_wr", {62'h0, RESP_SLVERR}, {62'h0, resp});
    // A second reset in mid-run restores the reset values, and the capability register catches the new strap.
    CAP_STRAP <= 16'h0031;
    RESET <= 1'b1;
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    repeat (8) @(posedge CLK);
    chk("rst_rate", 64'h0, 64'(LINK_RATE));
    chk("rst_mhz", 64'd200, 64'(LINK_RATE_MHZ));
    rd(ba(IDX_RATE_CTRL));
    chk("rst_ctrl", 64'(RATE_CTRL_RESET), 64'(rdat));
    rd(ba(IDX_WIN0_LO));
    chk("rst_win_lo", 64'(WIN0_RESET[31:0]), 64'(rdat));
    rd(ba(IDX_WIN0_HI));
    chk("rst_win_hi", 64'(WIN0_RESET[63:32]), 64'(rdat));
    rd(ba(IDX_EVT_STATUS));
    chk("rst_status", 64'h0, 64'(rdat));
    wr(ba(IDX_RATE_CAP), 32'hffff);
    rd(ba(IDX_RATE_CAP));
    chk("cap", 64'h0031, 64'(rdat));
    print_verdict();
  end
endmodule
`default_nettype wire
